// ==== include/sihlu_pkg.sv ====
// shared constants for the interleave, horizontal multiply and count unit
package sihlu_pkg;
	// ---------------------------------------------------------------
	// instruction field positions
	// ---------------------------------------------------------------
	localparam int SIHLU_MAJOR_MSB = 31;
	localparam int SIHLU_MAJOR_LSB = 26;
	localparam int SIHLU_RS_MSB = 25;
	localparam int SIHLU_RS_LSB = 21;
	localparam int SIHLU_RT_MSB = 20;
	localparam int SIHLU_RT_LSB = 16;
	localparam int SIHLU_RD_MSB = 15;
	localparam int SIHLU_RD_LSB = 11;
	localparam int SIHLU_SUB_MSB = 10;
	localparam int SIHLU_SUB_LSB = 6;
	localparam int SIHLU_FUNC_MSB = 5;
	localparam int SIHLU_FUNC_LSB = 0;
	// ---------------------------------------------------------------
	// encodings
	// ---------------------------------------------------------------
	localparam logic [5:0] SIHLU_MULTIMEDIA_MAJOR_OPCODE = 6'h1C;
	localparam logic [5:0] SIHLU_FUNC_GROUP_ONE = 6'h28;
	localparam logic [5:0] SIHLU_FUNC_GROUP_TWO = 6'h09;
	localparam logic [5:0] SIHLU_FUNC_GROUP_THREE = 6'h29;
	localparam logic [5:0] SIHLU_FUNC_GROUP_ZERO = 6'h04;
	localparam logic [4:0] SIHLU_SUB_EXT_UPPER_WORDS = 5'h12;
	localparam logic [4:0] SIHLU_SUB_HMUL_ADD = 5'h11;
	localparam logic [4:0] SIHLU_SUB_HMUL_SUB = 5'h15;
	localparam logic [4:0] SIHLU_SUB_INTERLEAVE = 5'h0A;
	localparam logic [4:0] SIHLU_SUB_LEAD_COUNT = 5'h00;
	// ---------------------------------------------------------------
	// timing and reset values
	// ---------------------------------------------------------------
	localparam int SIHLU_MUL_LATENCY = 3;
	localparam logic [127:0] SIHLU_ACC_RESET = 128'h0;
	// ---------------------------------------------------------------
	// operation selector
	// ---------------------------------------------------------------
	typedef enum logic [6:0] {
		SIHLU_OP_NONE = 7'h01,
		SIHLU_OP_EXT_UPPER_WORDS = 7'h02,
		SIHLU_OP_HMUL_ADD = 7'h04,
		SIHLU_OP_HMUL_SUB = 7'h08,
		SIHLU_OP_INTERLEAVE_EVEN = 7'h10,
		SIHLU_OP_INTERLEAVE_HALF = 7'h20,
		SIHLU_OP_LEAD_COUNT = 7'h40
	} sihlu_op_e;
endpackage

// ==== core/sihlu_unit.sv ====
// datapath for extend, horizontal multiply, interleave and leading count
`timescale 1ns/1ps
// Functional notes
// [RULE_01] decode upper-word extend: 011100/10010/101000
// [RULE_02] extend places rt,rs words two and three
// [RULE_03] decode horizontal mul-add: 011100/10001/001001
// [RULE_04] lane equals upper product plus lower product
// [RULE_05] decode horizontal mul-sub: 011100/10101/001001
// [RULE_06] lane equals upper product minus lower product
// [RULE_07] lanes go to rd and accumulator pair
// [RULE_08] no exception, results truncated to 32
// [RULE_09] stall accumulator reads until multiply done
// [RULE_10] decode even interleave: 011100/01010/101001
// [RULE_11] even interleave takes low halfwords of words
// [RULE_12] decode halfword interleave: 011100/01010/001001
// [RULE_13] halfword interleave: rt low, rs high doubleword
// [RULE_14] paired count of sign bits minus one
// [RULE_15] sources and destination are full 128 bits
// [RULE_16] standard field layout rs rt rd sub func
// [RULE_17] count destination above bit 63 don't-care
module sihlu_unit
	import sihlu_pkg::*;
#(
	parameter int MUL_LATENCY = SIHLU_MUL_LATENCY
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// issue from decode
	input wire logic issue_valid_in,
	input wire logic [31:0] instr_in,
	input wire logic [127:0] rs_data_in,
	input wire logic [127:0] rt_data_in,
	// accumulator read request from later instructions
	input wire logic acc_read_req_in,
	// result to register file
	output logic result_valid_out,
	output logic [4:0] result_rd_out,
	output logic [127:0] result_data_out,
	output logic illegal_out,
	// accumulator state and interlock
	output logic [127:0] lower_accumulator_out,
	output logic [127:0] upper_accumulator_out,
	output logic acc_read_stall_out,
	output logic acc_read_grant_out
);
	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic [5:0] major;
	logic [4:0] sub_op;
	logic [5:0] func;
	sihlu_op_e op;

	assign major = instr_in[SIHLU_MAJOR_MSB:SIHLU_MAJOR_LSB]; // RULE_16
	assign sub_op = instr_in[SIHLU_SUB_MSB:SIHLU_SUB_LSB]; // RULE_16
	assign func = instr_in[SIHLU_FUNC_MSB:SIHLU_FUNC_LSB]; // RULE_16

	// lead count encoding lies outside the quoted text; kept a constant
	always_comb begin
		op = SIHLU_OP_NONE;
		if (major == SIHLU_MULTIMEDIA_MAJOR_OPCODE) begin
			if (func == SIHLU_FUNC_GROUP_ONE &&
			    sub_op == SIHLU_SUB_EXT_UPPER_WORDS) begin
				op = SIHLU_OP_EXT_UPPER_WORDS; // RULE_01
			end else if (func == SIHLU_FUNC_GROUP_TWO &&
			    sub_op == SIHLU_SUB_HMUL_ADD) begin
				op = SIHLU_OP_HMUL_ADD; // RULE_03
			end else if (func == SIHLU_FUNC_GROUP_TWO &&
			    sub_op == SIHLU_SUB_HMUL_SUB) begin
				op = SIHLU_OP_HMUL_SUB; // RULE_05
			end else if (func == SIHLU_FUNC_GROUP_THREE &&
			    sub_op == SIHLU_SUB_INTERLEAVE) begin
				op = SIHLU_OP_INTERLEAVE_EVEN; // RULE_10
			end else if (func == SIHLU_FUNC_GROUP_TWO &&
			    sub_op == SIHLU_SUB_INTERLEAVE) begin
				op = SIHLU_OP_INTERLEAVE_HALF; // RULE_12
			end else if (func == SIHLU_FUNC_GROUP_ZERO &&
			    sub_op == SIHLU_SUB_LEAD_COUNT) begin
				op = SIHLU_OP_LEAD_COUNT;
			end
		end
	end

	// ---------------------------------------------------------------
	// lane arithmetic and permutes
	// ---------------------------------------------------------------
	logic [31:0] hadd [4];
	logic [31:0] hsub [4];
	logic [127:0] ext_word;
	logic [127:0] int_even;
	logic [127:0] int_half;
	logic [5:0] lcount [2];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			logic signed [31:0] p_hi;
			logic signed [31:0] p_lo;
			assign p_hi = $signed(rs_data_in[32*g+31 -: 16]) *
			    $signed(rt_data_in[32*g+31 -: 16]);
			assign p_lo = $signed(rs_data_in[32*g+15 -: 16]) *
			    $signed(rt_data_in[32*g+15 -: 16]);
			// wraps silently; no overflow flag is raised
			assign hadd[g] = 32'(p_hi + p_lo); // RULE_04 RULE_08
			assign hsub[g] = 32'(p_hi - p_lo); // RULE_06 RULE_08
			assign int_even[32*g+15 -: 16] =
			    rt_data_in[32*g+15 -: 16]; // RULE_11
			assign int_even[32*g+31 -: 16] =
			    rs_data_in[32*g+15 -: 16]; // RULE_11
			assign int_half[32*g+15 -: 16] =
			    rt_data_in[16*g+15 -: 16]; // RULE_13
			assign int_half[32*g+31 -: 16] =
			    rs_data_in[64+16*g+15 -: 16]; // RULE_13
		end
		for (g = 0; g < 2; g++) begin : g_count
			always_comb begin
				logic done;
				done = 1'b0;
				lcount[g] = 6'h00;
				for (int b = 30; b >= 0; b--) begin
					if (!done && rs_data_in[32*g+b] ==
					    rs_data_in[32*g+31]) begin
						lcount[g] = 6'(lcount[g] + 6'h01); // RULE_14
					end else begin
						done = 1'b1;
					end
				end
			end
		end
	endgenerate

	assign ext_word = {rs_data_in[127:96], rt_data_in[127:96],
	    rs_data_in[95:64], rt_data_in[95:64]}; // RULE_02

	// ---------------------------------------------------------------
	// result mux, full width
	// ---------------------------------------------------------------
	logic [127:0] result_d;
	logic is_mul;

	assign is_mul = (op == SIHLU_OP_HMUL_ADD) || (op == SIHLU_OP_HMUL_SUB);

	always_comb begin
		result_d = 128'h0;
		unique case (op)
			SIHLU_OP_NONE: result_d = 128'h0;
			SIHLU_OP_EXT_UPPER_WORDS: result_d = ext_word; // RULE_15
			SIHLU_OP_HMUL_ADD: begin
				result_d = {hadd[3], hadd[2], hadd[1], hadd[0]}; // RULE_07
			end
			SIHLU_OP_HMUL_SUB: begin
				result_d = {hsub[3], hsub[2], hsub[1], hsub[0]}; // RULE_07
			end
			SIHLU_OP_INTERLEAVE_EVEN: result_d = int_even; // RULE_15
			SIHLU_OP_INTERLEAVE_HALF: result_d = int_half; // RULE_15
			SIHLU_OP_LEAD_COUNT: begin
				// upper 64 bits are don't-care, driven as zero
				result_d = {64'h0, 26'h0, lcount[1],
				    26'h0, lcount[0]}; // RULE_17
			end
		endcase
	end

	// ---------------------------------------------------------------
	// register-file result
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			result_valid_out <= 1'b0;
			result_rd_out <= 5'h00;
			result_data_out <= 128'h0;
			illegal_out <= 1'b0;
		end else begin
			result_valid_out <= issue_valid_in &&
			    (op != SIHLU_OP_NONE);
			illegal_out <= issue_valid_in && (op == SIHLU_OP_NONE);
			if (issue_valid_in && op != SIHLU_OP_NONE) begin
				result_rd_out <= instr_in[SIHLU_RD_MSB:SIHLU_RD_LSB];
				result_data_out <= result_d;
			end
		end
	end

	// ---------------------------------------------------------------
	// accumulator pipe: results land MUL_LATENCY cycles after the register-file result
	// ---------------------------------------------------------------
	// a pending write is held while later non-multiply work proceeds;
	// a second multiply issued while busy restarts the wait with its
	// own lanes, which keeps program order for the accumulators
	logic [7:0] busy_cnt_q;
	logic [127:0] pend_q;
	logic [127:0] lo_q;
	logic [127:0] hi_q;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			busy_cnt_q <= 8'h00;
			pend_q <= 128'h0;
		end else if (issue_valid_in && is_mul) begin
			busy_cnt_q <= 8'(MUL_LATENCY); // RULE_09
			pend_q <= result_d;
		end else if (busy_cnt_q != 8'h00) begin
			busy_cnt_q <= 8'(busy_cnt_q - 8'h01);
		end
	end

	// undefined accumulator words are left holding their old value
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			lo_q <= SIHLU_ACC_RESET;
			hi_q <= SIHLU_ACC_RESET;
		end else if (busy_cnt_q == 8'h01 &&
		    !(issue_valid_in && is_mul)) begin
			lo_q[31:0] <= pend_q[31:0]; // RULE_07
			hi_q[31:0] <= pend_q[63:32]; // RULE_07
			lo_q[95:64] <= pend_q[95:64]; // RULE_07
			hi_q[95:64] <= pend_q[127:96]; // RULE_07
		end
	end

	assign lower_accumulator_out = lo_q;
	assign upper_accumulator_out = hi_q;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			acc_read_stall_out <= 1'b0;
			acc_read_grant_out <= 1'b0;
		end else begin
			acc_read_stall_out <= acc_read_req_in &&
			    ((busy_cnt_q > 8'h01) || (issue_valid_in && is_mul) ||
			    (busy_cnt_q == 8'h01)); // RULE_09
			acc_read_grant_out <= acc_read_req_in &&
			    (busy_cnt_q == 8'h00) &&
			    !(issue_valid_in && is_mul); // RULE_09
		end
	end
endmodule // sihlu_unit

// ==== test/sihlu_unit_assertions.sv ====
// checker for the interleave, multiply and count unit
`timescale 1ns/1ps
module sihlu_unit_assertions
	import sihlu_pkg::*;
#(
	parameter int MUL_LATENCY = 3
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// issue side
	input wire logic issue_valid_in,
	input wire logic [31:0] instr_in,
	input wire logic acc_read_req_in,
	// results and interlock
	input wire logic result_valid_out,
	input wire logic [4:0] result_rd_out,
	input wire logic illegal_out,
	input wire logic acc_read_stall_out,
	input wire logic acc_read_grant_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	wire logic [16:0] enc = {instr_in[31:26], instr_in[10:0]};
	wire logic mul = issue_valid_in && (enc == {6'h1C, 5'h11, 6'h09}
		|| enc == {6'h1C, 5'h15, 6'h09});
	chk_one_answer: assert property (issue_valid_in |=>
		result_valid_out != illegal_out) else $error("bad answer");
	chk_no_spurious: assert property (!issue_valid_in |=>
		!result_valid_out && !illegal_out) else $error("spurious result");
	chk_ext_decode: assert property (issue_valid_in &&
		enc == {6'h1C, 5'h12, 6'h28} |=> result_valid_out) else $error("ext");
	chk_madd_decode: assert property (issue_valid_in &&
		enc == {6'h1C, 5'h11, 6'h09} |=> result_valid_out) else $error("madd");
	chk_msub_decode: assert property (issue_valid_in &&
		enc == {6'h1C, 5'h15, 6'h09} |=> result_valid_out) else $error("msub");
	chk_even_decode: assert property (issue_valid_in &&
		enc == {6'h1C, 5'h0A, 6'h29} |=> result_valid_out) else $error("even");
	chk_half_decode: assert property (issue_valid_in &&
		enc == {6'h1C, 5'h0A, 6'h09} |=> result_valid_out) else $error("half");
	chk_dest_index: assert property (result_valid_out |->
		result_rd_out == $past(instr_in[15:11])) else $error("rd index");
	chk_mul_stalls: assert property (mul && acc_read_req_in |=>
		acc_read_stall_out && !acc_read_grant_out) else $error("no stall");
	// depth fixed for the default latency of three
	chk_quiet_grant: assert property (acc_read_req_in && !mul
		&& !$past(mul) && !$past(mul, 2) && !$past(mul, 3)
		|=> acc_read_grant_out) else $error("no grant");
	chk_grant_excl: assert property (acc_read_grant_out |->
		!acc_read_stall_out) else $error("grant while stalled");
endmodule // sihlu_unit_assertions
bind sihlu_unit sihlu_unit_assertions #(.MUL_LATENCY(MUL_LATENCY))
	sihlu_unit_assertions_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.issue_valid_in(issue_valid_in), .instr_in(instr_in),
	.acc_read_req_in(acc_read_req_in), .result_valid_out(result_valid_out),
	.result_rd_out(result_rd_out), .illegal_out(illegal_out),
	.acc_read_stall_out(acc_read_stall_out),
	.acc_read_grant_out(acc_read_grant_out));

// ==== test/simd_interleave_hmac_lzc_unit_bench.sv ====
// self-checking bench for the interleave, multiply and count unit
`timescale 1ns/1ps
module simd_interleave_hmac_lzc_unit_bench
	import sihlu_pkg::*;
;
	localparam logic [127:0] PA = 128'h80007FFF12348000FFFF000280008000;
	localparam logic [127:0] PB = 128'h80007FFFABCD0003FFFF000480008000;
	logic clk_in = 0, sys_rst_in = 1, iv = 0, req = 0;
	logic [31:0] ins = 0;
	logic [127:0] a = 0, b = 0, res, lo, hi;
	logic rv, il, st, gr;
	logic [4:0] rd;
	int bad_count = 0, n_checks = 0;
	sihlu_unit sihlu_unit_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.issue_valid_in(iv), .instr_in(ins), .rs_data_in(a),
		.rt_data_in(b), .acc_read_req_in(req), .result_valid_out(rv),
		.result_rd_out(rd), .result_data_out(res), .illegal_out(il),
		.lower_accumulator_out(lo), .upper_accumulator_out(hi),
		.acc_read_stall_out(st), .acc_read_grant_out(gr));
	initial forever #20 clk_in = ~clk_in;
	task automatic finish_test();
		if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input logic [127:0] g, e, input string m);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	function automatic logic [31:0] op(logic [4:0] s, logic [5:0] f);
		return {6'h1C, 5'h01, 5'h02, 5'h05, s, f};
	endfunction
	// one idle cycle between issues keeps every input single-driven
	task automatic run(input logic [31:0] i, input logic [127:0] x, y,
		e, m, input logic q);
		@(posedge clk_in);
		#1 ins = i;
		a = x;
		b = y;
		req = q;
		iv = 1;
		@(posedge clk_in);
		#1 iv = 0;
		cmp(rv, 1, "no result");
		cmp(res & m, e & m, "result data");
	endtask
	function automatic logic [127:0] hm(logic [127:0] x, y, logic s);
		logic [31:0] u, v;
		for (int g = 0; g < 4; g++) begin
			u = $signed(x[32*g+16+:16]) * $signed(y[32*g+16+:16]);
			v = $signed(x[32*g+:16]) * $signed(y[32*g+:16]);
			hm[32*g+:32] = s ? u - v : u + v;
		end
	endfunction
	function automatic logic [5:0] lc(logic [31:0] w);
		lc = 0;
		for (int i = 30; i >= 0 && w[i] == w[31]; i--) lc++;
	endfunction
	task automatic t_ext();
		run(op(5'h12, 6'h28), PA, PB, {PA[127:96], PB[127:96],
			PA[95:64], PB[95:64]}, '1, 0);
	endtask
	task automatic t_mul(input logic s);
		logic [127:0] e;
		e = hm(PA, PB, s);
		run(op(s ? 5'h15 : 5'h11, 6'h09), PA, PB, e, '1, 1);
		cmp(st, 1, "no stall");
		for (int k = 0; k < 8 && gr !== 1'b1; k++) @(posedge clk_in) #1;
		req = 0;
		cmp(gr, 1, "no grant");
		cmp({hi[95:64], lo[95:64], hi[31:0], lo[31:0]}, e, "acc");
	endtask
	task automatic t_even();
		run(op(5'h0A, 6'h29), PA, PB, {PA[111:96], PB[111:96],
			PA[79:64], PB[79:64], PA[47:32], PB[47:32],
			PA[15:0], PB[15:0]}, '1, 0);
	endtask
	task automatic t_half();
		run(op(5'h0A, 6'h09), PA, PB, {PA[127:112], PB[63:48],
			PA[111:96], PB[47:32], PA[95:80], PB[31:16],
			PA[79:64], PB[15:0]}, '1, 0);
	endtask
	task automatic t_lzc();
		logic [127:0] x;
		for (int n = 0; n < 2; n++) begin
			x = n ? PA : {96'h0, 32'hFFFFFFFF};
			run(op(5'h00, 6'h04), x, PB, {90'h0, lc(x[63:32]), 26'h0,
				lc(x[31:0])}, {64'h0, {64{1'b1}}}, 0);
		end
	endtask
	task automatic t_bad();
		@(posedge clk_in);
		#1 ins = op(5'h0A, 6'h28);
		iv = 1;
		@(posedge clk_in);
		#1 iv = 0;
		cmp({il, rv}, 2'b10, "not refused");
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		#1 sys_rst_in = 0;
		t_ext();
		t_mul(0);
		t_mul(1);
		t_even();
		t_half();
		t_lzc();
		t_bad();
		finish_test();
	end
	initial begin
		#20000;
		bad_count++;
		finish_test();
	end
endmodule // simd_interleave_hmac_lzc_unit_bench
